// ---- design/mode_reg_pkg.sv ----
// Summary of operation
// - reading temperature status clears update flag
// - update flag is zero after power-up
// - rate bit two high above 85 C
// - rate change since last read sets flag
// - code 110 quarter interval with derating
// - rate field bits 2:0, 000 low limit
// - address 05h returns fixed vendor code
// - addresses 06h, 07h return revision codes
// - organisation bits 1:0 report S4 type
// - organisation bits 5:2 report density 0011
// - organisation bits 7:6 report bus width
// - calibration writes ab long, 56 short
// - calibration writes ff init, c3 reset
// - undefined calibration codes are ignored
// - supply strap blocks long and short calibration
// - bank mask bit one blocks bank refresh
// - only bank mask bits 3:0 are used
package mode_reg_pkg;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_TEMP_STATUS = 8'h04;
    localparam logic [7:0] ADDR_VENDOR = 8'h05;
    localparam logic [7:0] ADDR_REVISION_ONE = 8'h06;
    localparam logic [7:0] ADDR_REVISION_TWO = 8'h07;
    localparam logic [7:0] ADDR_ORGANISATION = 8'h08;
    localparam logic [7:0] ADDR_VENDOR_TEST = 8'h09;
    localparam logic [7:0] ADDR_CALIBRATION = 8'h0a;
    localparam logic [7:0] ADDR_RESERVED_LOW = 8'h0b;
    localparam logic [7:0] ADDR_RESERVED_HIGH = 8'h0f;
    localparam logic [7:0] ADDR_BANK_MASK = 8'h10;

    // ------------------------------------------------------------
    // field positions and codes
    // ------------------------------------------------------------
    localparam int FLAG_BIT = 7;
    localparam int RATE_HOT_BIT = 2;
    localparam logic [2:0] RATE_LOW_LIMIT = 3'h0;
    localparam logic [2:0] RATE_QUARTER = 3'h5;
    localparam logic [2:0] RATE_QUARTER_DERATE = 3'h6;
    localparam logic [2:0] RATE_HIGH_LIMIT = 3'h7;
    localparam logic [1:0] TYPE_S4 = 2'h0;
    localparam logic [3:0] DENSITY_512MB = 4'h3;
    localparam logic [1:0] WIDTH_X32 = 2'h0;
    localparam logic [1:0] WIDTH_X16 = 2'h1;
    localparam logic [7:0] CAL_CODE_INIT = 8'hff;
    localparam logic [7:0] CAL_CODE_LONG = 8'hab;
    localparam logic [7:0] CAL_CODE_SHORT = 8'h56;
    localparam logic [7:0] CAL_CODE_RESET = 8'hc3;
    localparam logic [7:0] READ_FILL = 8'h00;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic FLAG_RESET = 1'b0;
    localparam logic [2:0] RATE_RESET = 3'h3;
    localparam logic [7:0] BANK_MASK_RESET = 8'h00;

    typedef enum logic [2:0] {
        CAL_NONE,
        CAL_INIT,
        CAL_LONG,
        CAL_SHORT,
        CAL_RESET
    } cal_cmd_t;

endpackage

// ---- design/refresh_rate_tracker.sv ----
`timescale 1ns/10ps
module refresh_rate_tracker (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [2:0] sensor_rate,
    input wire logic read_clear,
    output logic [2:0] rate_code,
    output logic update_flag
);

    typedef struct packed {
        logic primed;
        logic [2:0] code;
        logic flag;
    } track_t;

    track_t st_ff;
    track_t nxt_st;
    logic changed;

    // ------------------------------------------------------------
    // change tracking
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        changed = st_ff.primed && (sensor_rate != st_ff.code);
        nxt_st.primed = 1'b1;
        nxt_st.code = sensor_rate;
        // a change in the clearing cycle must not be lost
        if (changed) begin
            nxt_st.flag = 1'b1;
        end else if (read_clear) begin
            nxt_st.flag = 1'b0;
        end
    end

    // first sample after reset loads the code without raising the flag
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{primed: 1'b0,
                       code: mode_reg_pkg::RATE_RESET,
                       flag: mode_reg_pkg::FLAG_RESET};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rate_code = st_ff.code;
    assign update_flag = st_ff.flag;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    flag_set_a: assert property (
        st_ff.primed && sensor_rate != rate_code |=> update_flag)
        else $error("rate change did not raise the flag");
    flag_clear_a: assert property (
        read_clear && !changed |=> !update_flag)
        else $error("status read did not clear the flag");
    flag_powerup_a: assert property (
        !st_ff.primed |-> !update_flag ##1 !update_flag)
        else $error("flag set right after power-up");
    flag_hold_a: assert property (
        !changed && !read_clear |=> update_flag == $past(update_flag))
        else $error("flag moved without cause");

endmodule

// ---- design/mode_register_file.sv ----
`timescale 1ns/10ps
module mode_register_file #(
    parameter int data_width = 32,
    parameter int bank_count = 4,
    // arbitrary value
    parameter logic [7:0] vendor_code = 8'h5a,
    // arbitrary value
    parameter logic [7:0] revision_one = 8'h0a,
    // arbitrary value
    parameter logic [7:0] revision_two = 8'h0b
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic mrr_valid,
    input wire logic mrw_valid,
    input wire logic [7:0] mode_addr,
    input wire logic [7:0] write_data,
    input wire logic [2:0] sensor_rate,
    input wire logic ref_pin_at_supply,
    output logic read_valid,
    output logic [7:0] read_data,
    output logic [bank_count-1:0] bank_refresh_mask,
    output logic cal_init_start,
    output logic cal_long_start,
    output logic cal_short_start,
    output logic cal_reset_start,
    output logic derate_required,
    output logic rate_out_of_range
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic rd_valid;
        logic [7:0] rd_data;
        logic [bank_count-1:0] mask;
        logic cal_init;
        logic cal_long;
        logic cal_short;
        logic cal_reset;
        logic strap_seen;
        logic strap_supply;
        logic derate;
        logic out_of_range;
    } regs_t;

    regs_t st_ff;
    regs_t nxt_st;

    logic [2:0] rate_code;
    logic update_flag;
    logic status_read;
    logic cal_write;
    logic mask_write;
    logic strap_now;
    logic [1:0] width_code;
    logic [7:0] temp_word;
    logic [7:0] org_word;
    logic [7:0] read_word;
    mode_reg_pkg::cal_cmd_t cal_cmd;

    // ------------------------------------------------------------
    // strobes
    // ------------------------------------------------------------
    assign status_read = mrr_valid &&
        (mode_addr == mode_reg_pkg::ADDR_TEMP_STATUS);
    assign cal_write = mrw_valid &&
        (mode_addr == mode_reg_pkg::ADDR_CALIBRATION);
    assign mask_write = mrw_valid &&
        (mode_addr == mode_reg_pkg::ADDR_BANK_MASK);

    // strap is sampled at the first edge after reset; until then the
    // live pin is used so an early command sees the same answer
    assign strap_now = st_ff.strap_seen ? st_ff.strap_supply :
        ref_pin_at_supply;

    assign width_code = (data_width == 16) ? mode_reg_pkg::WIDTH_X16 :
        mode_reg_pkg::WIDTH_X32;

    // ------------------------------------------------------------
    // temperature tracking
    // ------------------------------------------------------------
    refresh_rate_tracker tracker (
        .clock(clock),
        .rst_n(rst_n),
        .sensor_rate(sensor_rate),
        .read_clear(status_read),
        .rate_code(rate_code),
        .update_flag(update_flag)
    );

    // ------------------------------------------------------------
    // read words
    // ------------------------------------------------------------
    always_comb begin
        temp_word = 8'h00;
        // flag is returned before the read clears it
        temp_word[mode_reg_pkg::FLAG_BIT] = update_flag;
        // sensor code passes through unchanged, so bit two is the
        // above-85 indication and 000 the low limit
        temp_word[2:0] = rate_code;
    end

    assign org_word = {width_code, mode_reg_pkg::DENSITY_512MB,
        mode_reg_pkg::TYPE_S4};

    // write-only, test and reserved addresses read as fill
    always_comb begin
        read_word = mode_reg_pkg::READ_FILL;
        unique case (mode_addr)
            mode_reg_pkg::ADDR_TEMP_STATUS: begin
                read_word = temp_word;
            end
            mode_reg_pkg::ADDR_VENDOR: begin
                read_word = vendor_code;
            end
            mode_reg_pkg::ADDR_REVISION_ONE: begin
                read_word = revision_one;
            end
            mode_reg_pkg::ADDR_REVISION_TWO: begin
                read_word = revision_two;
            end
            mode_reg_pkg::ADDR_ORGANISATION: begin
                read_word = org_word;
            end
            default: begin
                read_word = mode_reg_pkg::READ_FILL;
            end
        endcase
    end

    // ------------------------------------------------------------
    // calibration decode
    // ------------------------------------------------------------
    always_comb begin
        cal_cmd = mode_reg_pkg::CAL_NONE;
        unique case (write_data)
            mode_reg_pkg::CAL_CODE_INIT: begin
                cal_cmd = mode_reg_pkg::CAL_INIT;
            end
            mode_reg_pkg::CAL_CODE_LONG: begin
                cal_cmd = mode_reg_pkg::CAL_LONG;
            end
            mode_reg_pkg::CAL_CODE_SHORT: begin
                cal_cmd = mode_reg_pkg::CAL_SHORT;
            end
            mode_reg_pkg::CAL_CODE_RESET: begin
                cal_cmd = mode_reg_pkg::CAL_RESET;
            end
            default: begin
                cal_cmd = mode_reg_pkg::CAL_NONE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rd_valid = mrr_valid;
        nxt_st.cal_init = 1'b0;
        nxt_st.cal_long = 1'b0;
        nxt_st.cal_short = 1'b0;
        nxt_st.cal_reset = 1'b0;
        nxt_st.strap_seen = 1'b1;
        if (!st_ff.strap_seen) begin
            nxt_st.strap_supply = ref_pin_at_supply;
        end
        if (mrr_valid) begin
            nxt_st.rd_data = read_word;
        end
        // a pin tied to the supply means default calibration only:
        // only the reset to defaults still acts
        if (cal_write) begin
            nxt_st.cal_reset = (cal_cmd == mode_reg_pkg::CAL_RESET);
            if (!strap_now) begin
                nxt_st.cal_init = (cal_cmd == mode_reg_pkg::CAL_INIT);
                nxt_st.cal_long = (cal_cmd == mode_reg_pkg::CAL_LONG);
                nxt_st.cal_short = (cal_cmd == mode_reg_pkg::CAL_SHORT);
            end
        end
        // upper operand bits have no bank behind them
        if (mask_write) begin
            nxt_st.mask = write_data[bank_count-1:0];
        end
        nxt_st.derate =
            (rate_code == mode_reg_pkg::RATE_QUARTER_DERATE);
        // the controller acts on this; the device only flags it
        nxt_st.out_of_range =
            (rate_code == mode_reg_pkg::RATE_LOW_LIMIT) ||
            (rate_code == mode_reg_pkg::RATE_HIGH_LIMIT);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{rd_valid: 1'b0,
                       rd_data: mode_reg_pkg::READ_FILL,
                       mask: mode_reg_pkg::BANK_MASK_RESET[
                           bank_count-1:0],
                       cal_init: 1'b0,
                       cal_long: 1'b0,
                       cal_short: 1'b0,
                       cal_reset: 1'b0,
                       strap_seen: 1'b0,
                       strap_supply: 1'b0,
                       derate: 1'b0,
                       out_of_range: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign read_valid = st_ff.rd_valid;
    assign read_data = st_ff.rd_data;
    assign bank_refresh_mask = st_ff.mask;
    assign cal_init_start = st_ff.cal_init;
    assign cal_long_start = st_ff.cal_long;
    assign cal_short_start = st_ff.cal_short;
    assign cal_reset_start = st_ff.cal_reset;
    assign derate_required = st_ff.derate;
    assign rate_out_of_range = st_ff.out_of_range;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence long_write_s;
        cal_write && write_data == 8'hab && !strap_now;
    endsequence

    sequence one_pulse_s(sig);
        sig ##1 !sig;
    endsequence

    read_answer_a: assert property (
        mrr_valid |=> read_valid ##1 (read_valid == $past(mrr_valid)))
        else $error("read answer not one cycle after command");

    status_read_a: assert property (
        status_read |=> read_data[2:0] == $past(rate_code) &&
            read_data[6:3] == 4'h0)
        else $error("rate field returned wrong");

    flag_return_a: assert property (
        status_read |=>
            read_data[mode_reg_pkg::FLAG_BIT] == $past(update_flag))
        else $error("flag bit returned wrong");

    flag_cleared_a: assert property (
        status_read && sensor_rate == rate_code |=> !update_flag)
        else $error("flag not cleared by status read");

    write_only_read_a: assert property (
        mrr_valid && (mode_addr == mode_reg_pkg::ADDR_CALIBRATION ||
            mode_addr == mode_reg_pkg::ADDR_BANK_MASK) |=>
            read_data == 8'h00)
        else $error("write-only register read not zero");

    vendor_read_a: assert property (
        mrr_valid && mode_addr == 8'h05 |=> read_data == vendor_code)
        else $error("vendor code returned wrong");

    revision_read_a: assert property (
        mrr_valid && mode_addr == 8'h06 |=> read_data == revision_one
        ##0 1'b1)
        else $error("first revision code returned wrong");

    revision_two_a: assert property (
        mrr_valid && mode_addr == 8'h07 |=> read_data == revision_two)
        else $error("second revision code returned wrong");

    org_read_a: assert property (
        mrr_valid && mode_addr == 8'h08 |=>
            read_data[1:0] == 2'h0 && read_data[5:2] == 4'h3 &&
            read_data[7:6] == ((data_width == 16) ? 2'h1 : 2'h0))
        else $error("organisation returned wrong");

    unmapped_read_a: assert property (
        mrr_valid && mode_addr >= 8'h09 |=> read_data == 8'h00)
        else $error("unmapped address read not zero");

    cal_long_a: assert property (
        long_write_s |=> one_pulse_s(cal_long_start) and
            (!cal_short_start && !cal_init_start))
        else $error("long calibration not started once");

    cal_short_a: assert property (
        cal_write && write_data == 8'h56 && !strap_now |=>
            one_pulse_s(cal_short_start))
        else $error("short calibration not started once");

    cal_init_a: assert property (
        cal_write && write_data == 8'hff && !strap_now |=>
            cal_init_start && !cal_long_start)
        else $error("init calibration not started");

    cal_reset_a: assert property (
        cal_write && write_data == 8'hc3 |=> cal_reset_start)
        else $error("calibration reset not started");

    cal_ignore_a: assert property (
        cal_write && cal_cmd == mode_reg_pkg::CAL_NONE |=>
            !cal_init_start && !cal_long_start &&
            !cal_short_start && !cal_reset_start)
        else $error("undefined calibration code acted");

    strap_block_a: assert property (
        cal_write && strap_now |=>
            !cal_long_start && !cal_short_start && !cal_init_start)
        else $error("strapped pin let calibration run");

    no_stray_cal_a: assert property (
        !cal_write |=> !cal_long_start && !cal_short_start)
        else $error("calibration pulse without a write");

    mask_write_a: assert property (
        mask_write |=> bank_refresh_mask == $past(write_data[3:0]))
        else $error("bank mask not loaded");

    mask_hold_a: assert property (
        !mask_write |=> $stable(bank_refresh_mask))
        else $error("bank mask changed without a write");

    derate_a: assert property (
        rate_code == 3'h6 |=> derate_required [*1] ##0
            !rate_out_of_range)
        else $error("derating not flagged for code 110");

    no_derate_a: assert property (
        rate_code == 3'h5 |=> !derate_required)
        else $error("derating flagged for code 101");

    range_a: assert property (
        rate_code == 3'h0 || rate_code == 3'h7 |=> rate_out_of_range)
        else $error("out of range code not flagged");

endmodule

// ---- test/host_controller_model.sv ----
`timescale 1ns/10ps
module host_controller_model (
    input wire logic clock,
    input wire logic read_valid,
    input wire logic [7:0] read_data,
    input wire logic derate_required,
    input wire logic rate_out_of_range,
    output logic mrr_valid,
    output logic mrw_valid,
    output logic [7:0] mode_addr,
    output logic [7:0] write_data
);
    // ------------------------------------------------------------
    // host view of device status
    // ------------------------------------------------------------
    logic device_trusted;
    int extra_ps;

    // stop relying on the device at codes 000 and 111
    always_comb device_trusted = !rate_out_of_range;
    // core timings stretched by 1.875 ns, clock untouched
    always_comb extra_ps = derate_required ? 1875 : 0;

    initial begin
        mrr_valid = 1'b0;
        mrw_valid = 1'b0;
        mode_addr = 8'h00;
        write_data = 8'h00;
    end

    // ------------------------------------------------------------
    // command tasks
    // ------------------------------------------------------------
    // released lines show the inverse, not a stale value
    task automatic mode_read(input logic [7:0] addr,
                             output logic [7:0] data,
                             output logic valid);
        @(negedge clock);
        mrr_valid = 1'b1;
        mode_addr = addr;
        // answer stands for one cycle only, so take it before release
        @(negedge clock);
        valid = read_valid;
        data = read_data;
        mrr_valid = 1'b0;
        mode_addr = ~addr;
    endtask

    // writes to the vendor test and reserved addresses 09h, 0bh-0fh are dropped
    task automatic mode_write(input logic [7:0] addr,
                              input logic [7:0] data);
        if (addr == 8'h09 || (addr >= 8'h0b && addr <= 8'h0f)) begin
            return;
        end
        @(negedge clock);
        mrw_valid = 1'b1;
        mode_addr = addr;
        write_data = data;
        // returns while a calibration pulse still stands
        @(negedge clock);
        mrw_valid = 1'b0;
        mode_addr = ~addr;
        write_data = ~data;
    endtask
endmodule

// ---- test/test_sdram_mode_register_file.sv ----
`timescale 1ns/10ps
module test_sdram_mode_register_file;
    localparam logic [7:0] vendor_id = 8'h3c; // arbitrary
    localparam logic [7:0] rev_a = 8'h01; // arbitrary
    localparam logic [7:0] rev_b = 8'h02; // arbitrary

    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] sensor_rate = 3'h3;
    logic ref_pin_at_supply = 1'b0;
    logic mrr_valid, mrw_valid, read_valid;
    logic [7:0] mode_addr, write_data, read_data;
    logic [3:0] bank_refresh_mask;
    logic cal_init_start, cal_long_start;
    logic cal_short_start, cal_reset_start;
    logic derate_required, rate_out_of_range;
    int error_cnt = 0;
    int n_compared = 0;

    always #5 clock = ~clock;

    mode_register_file #(.data_width(32), .bank_count(4),
        .vendor_code(vendor_id), .revision_one(rev_a),
        .revision_two(rev_b)) i_mode_register_file (
        .clock(clock), .rst_n(rst_n), .mrr_valid(mrr_valid),
        .mrw_valid(mrw_valid), .mode_addr(mode_addr),
        .write_data(write_data), .sensor_rate(sensor_rate),
        .ref_pin_at_supply(ref_pin_at_supply),
        .read_valid(read_valid), .read_data(read_data),
        .bank_refresh_mask(bank_refresh_mask),
        .cal_init_start(cal_init_start),
        .cal_long_start(cal_long_start),
        .cal_short_start(cal_short_start),
        .cal_reset_start(cal_reset_start),
        .derate_required(derate_required),
        .rate_out_of_range(rate_out_of_range));

    host_controller_model i_host_controller_model (
        .clock(clock), .read_valid(read_valid),
        .read_data(read_data), .derate_required(derate_required),
        .rate_out_of_range(rate_out_of_range),
        .mrr_valid(mrr_valid), .mrw_valid(mrw_valid),
        .mode_addr(mode_addr), .write_data(write_data));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        i_host_controller_model.mode_read(addr, d, v);
        check({7'h00, v}, 8'h01);
        check(d, exp);
    endtask

    task automatic do_reset();
        @(negedge clock);
        rst_n = 1'b0;
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
    endtask

    function automatic logic [7:0] cal_bits();
        return {4'h0, cal_init_start, cal_long_start,
                cal_short_start, cal_reset_start};
    endfunction

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_power_up();
        rd(mode_reg_pkg::ADDR_TEMP_STATUS, 8'h03);
        check({4'h0, bank_refresh_mask}, 8'h00);
        $display("power-up test done");
    endtask

    task automatic t_ident();
        rd(mode_reg_pkg::ADDR_VENDOR, vendor_id);
        rd(mode_reg_pkg::ADDR_REVISION_ONE, rev_a);
        rd(mode_reg_pkg::ADDR_REVISION_TWO, rev_b);
        rd(mode_reg_pkg::ADDR_ORGANISATION, {mode_reg_pkg::WIDTH_X32,
            mode_reg_pkg::DENSITY_512MB, mode_reg_pkg::TYPE_S4});
        rd(mode_reg_pkg::ADDR_ORGANISATION, 8'h0c);
        i_host_controller_model.mode_write(8'h05, 8'hff);
        rd(mode_reg_pkg::ADDR_VENDOR, vendor_id);
        rd(mode_reg_pkg::ADDR_VENDOR_TEST, 8'h00);
        rd(mode_reg_pkg::ADDR_RESERVED_LOW, 8'h00);
        $display("identity test done");
    endtask

    task automatic t_temp();
        @(negedge clock);
        sensor_rate = 3'h6;
        repeat (3) @(posedge clock);
        #1;
        check({7'h00, derate_required}, 8'h01);
        rd(mode_reg_pkg::ADDR_TEMP_STATUS, 8'h86);
        rd(mode_reg_pkg::ADDR_TEMP_STATUS, 8'h06);
        @(negedge clock);
        sensor_rate = 3'h7;
        repeat (3) @(posedge clock);
        #1;
        check({7'h00, rate_out_of_range}, 8'h01);
        @(negedge clock);
        sensor_rate = 3'h0;
        repeat (3) @(posedge clock);
        #1;
        check({7'h00, rate_out_of_range}, 8'h01);
        rd(mode_reg_pkg::ADDR_TEMP_STATUS, 8'h80);
        sensor_rate = 3'h5;
        repeat (3) @(posedge clock);
        #1;
        check({6'h00, derate_required, rate_out_of_range}, 8'h00);
        rd(mode_reg_pkg::ADDR_TEMP_STATUS, 8'h85);
        $display("temperature test done");
    endtask

    // strap high leaves only the reset-to-default code active
    task automatic t_cal(input logic strap);
        logic [7:0] codes[5] = '{8'hff, 8'hab, 8'h56, 8'hc3, 8'h12};
        logic [7:0] exp[5] = '{8'h08, 8'h04, 8'h02, 8'h01, 8'h00};
        @(negedge clock);
        ref_pin_at_supply = strap;
        do_reset();
        for (int k = 0; k < 5; k++) begin
            i_host_controller_model.mode_write(
                mode_reg_pkg::ADDR_CALIBRATION, codes[k]);
            check(cal_bits(), (strap && k != 3) ? 8'h00 : exp[k]);
            @(posedge clock);
            #1;
            check(cal_bits(), 8'h00);
        end
        $display("calibration test done, strap %0d", strap);
    endtask

    task automatic t_mask();
        i_host_controller_model.mode_write(
            mode_reg_pkg::ADDR_BANK_MASK, 8'hf5);
        check({4'h0, bank_refresh_mask}, 8'h05);
        i_host_controller_model.mode_write(
            mode_reg_pkg::ADDR_BANK_MASK, 8'h0a);
        check({4'h0, bank_refresh_mask}, 8'h0a);
        i_host_controller_model.mode_write(8'h04, 8'hff);
        check({4'h0, bank_refresh_mask}, 8'h0a);
        rd(mode_reg_pkg::ADDR_BANK_MASK, 8'h00);
        $display("bank mask test done");
    endtask

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        t_power_up();
        t_ident();
        t_temp();
        t_mask();
        t_cal(1'b0);
        t_cal(1'b1);
        close_out();
    end

    // whole run is about a hundred cycles
    initial begin
        #50000;
        error_cnt++;
        close_out();
    end
endmodule
